// ==== rtl/sib_pkg.sv ====
// constants, types and helpers shared by the serial idle/break block
package sib_pkg;
    localparam logic [5:0]  OFS_BAUD   = 6'h00;
    localparam logic [5:0]  OFS_CTRL1  = 6'h04;
    localparam logic [5:0]  OFS_CTRL2  = 6'h08;
    localparam logic [5:0]  OFS_FLAGS  = 6'h0c;
    localparam logic [5:0]  OFS_MASK   = 6'h10;
    localparam logic [5:0]  OFS_DATA   = 6'h14;
    localparam int          C1_LONG    = 0;
    localparam int          C1_PAR_EN  = 1;
    localparam int          C1_PAR_ODD = 2;
    localparam int          C2_TX_EN   = 0;
    localparam int          C2_RX_EN   = 1;
    localparam int          C2_SBK     = 2;
    localparam int          C2_BKD_EN  = 3;
    localparam int          F_TX_BUFFER_EMPTY_FLAG     = 0;
    localparam int          F_TC       = 1;
    localparam int          F_RX_FULL_FLAG     = 2;
    localparam int          F_OVR      = 3;
    localparam int          F_NOISE    = 4;
    localparam int          F_FRAME    = 5;
    localparam int          F_PAR      = 6;
    localparam int          F_BRK      = 7;
    localparam int          F_RXACT    = 8;
    localparam logic [8:0]  STICKY     = 9'h0fc;
    localparam logic [12:0] BAUD_RST   = 13'h0041;
    localparam logic [3:0]  SUB_LAST   = 4'hf;
    localparam logic [3:0]  SUB_MID    = 4'h9;
    localparam logic [3:0]  BRK_SHORT  = 4'ha;
    localparam logic [3:0]  BRK_LONG   = 4'hb;
    localparam logic [3:0]  BITS_SHORT = 4'h8;
    localparam logic [3:0]  BITS_LONG  = 4'h9;
    localparam logic [3:0]  MARK_BITS  = 4'h1;
    localparam logic [10:0] LINE_ONES  = 11'h7ff;

    typedef enum logic [1:0] {LD_DATA, LD_BREAK, LD_MARK, LD_PREAMBLE}
        sib_load_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_WAIT_HI}
        sib_rx_t;

    typedef struct packed {
        logic maj;
        logic noisy;
    } sib_samp_t;

    typedef struct packed {
        logic [12:0] cnt;
        logic        tick;
    } sib_baud_st_t;

    typedef struct packed {
        logic [2:0] win;
    } sib_win_st_t;

    typedef struct packed {
        logic        pend;
        logic [31:0] rdata;
        logic [2:0]  c1;
        logic [3:0]  c2;
        logic [12:0] baud;
        logic [8:0]  mask;
        logic [8:0]  flags;
        logic        irq;
        logic [8:0]  tx_buf;
        logic        tx_buffer_empty_flag;
        logic        pre_pend;
        logic        brk_tail;
        logic        tx_busy;
        sib_load_t   tx_kind;
        logic [10:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic [3:0]  tx_sub;
        sib_rx_t     rx_st;
        logic [3:0]  rx_sub;
        logic [3:0]  rx_cnt;
        logic [3:0]  rx_zc;
        logic        rx_hold;
        logic [8:0]  rx_sh;
        logic [8:0]  rx_data;
    } sib_state_t;

    function automatic logic sib_par(input logic [8:0] d, input logic lng,
                                     input logic odd);
        return (lng ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction : sib_par

    // start bit in bit 0; short frames carry their stop bit in bit 9
    function automatic logic [10:0] sib_frame(input logic [8:0] d,
        input logic lng, input logic pe, input logic odd);
        logic [8:0] p;
        p = d;
        if (pe && lng) p[8] = sib_par(d, lng, odd);
        if (pe && !lng) p[7] = sib_par(d, lng, odd);
        if (!lng) p[8] = 1'b1;
        return {1'b1, p, 1'b0};
    endfunction : sib_frame
endpackage : sib_pkg

// ==== rtl/sib_baud.sv ====
// oversample tick generator, sixteen ticks per bit
`timescale 1ns/100ps
module sib_baud (
    input  logic        clk,
    input  logic        rst,
    input  logic [12:0] div,
    output logic        tick
);
    sib_pkg::sib_baud_st_t s_reg;
    sib_pkg::sib_baud_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        // a divisor of 0 or 1 gives a tick every clock
        if ((s_reg.cnt + 13'h1) >= div) begin
            s_next.cnt = 13'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 13'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign tick = s_reg.tick;
endmodule : sib_baud

// ==== rtl/sib_rx_sample.sv ====
// three-sample majority vote and noise detect on the receive line
`timescale 1ns/100ps
module sib_rx_sample (
    input  logic                clk,
    input  logic                rst,
    input  logic                tick,
    input  logic                rxd,
    output sib_pkg::sib_samp_t  smp
);
    sib_pkg::sib_win_st_t s_reg;
    sib_pkg::sib_win_st_t s_next;

    always_comb begin
        s_next = s_reg;
        if (tick) s_next.win = {s_reg.win[1:0], rxd};
    end

    always_ff @(posedge clk) begin
        if (rst) s_reg.win <= 3'h7;
        else s_reg <= s_next;
    end

    // disagreeing samples flag noise but the majority still wins
    assign smp.maj = (s_reg.win[0] & s_reg.win[1]) |
                     (s_reg.win[0] & s_reg.win[2]) |
                     (s_reg.win[1] & s_reg.win[2]);
    assign smp.noisy = ~(&s_reg.win) & (|s_reg.win);
endmodule : sib_rx_sample

// ==== rtl/sib_top.sv ====
// serial transmitter and receiver with idle, preamble and break handling
`timescale 1ns/100ps
// What this block does
// - the transmit pin sits at 1 whenever no frame is being shifted out.
// - clearing transmit enable drops the internal enable and idles the line.
// - a frame already shifting when enable clears is sent to its end.
// - buffer-empty rises when the data word moves into the shifter.
// - turning enable off then on queues a preamble ahead of the next frame.
// - writing 1 to send-break loads a break character into the shifter.
// - a break is all zeros, no start, stop or parity, 10 or 11 bits long.
// - while send-break stays 1 break characters follow back to back.
// - once send-break clears the break ends and at least one 1 follows.
// - the receiver sees a break after 10 or 11 zero samples in a row.
// - with break detect off a break sets framing and full, zeroes data.
// - with break detect off overrun, noise and active may also set; parity does not.
// - with break detect on a break sets the break flag at any bit.
// - with break detect on full, overrun, framing, parity, data hold still.
module sib_top (
    input  logic        SYS_CLK,
    input  logic        SYS_RST,
    input  logic [5:0]  AVS_ADDRESS,
    input  logic        AVS_READ,
    input  logic        AVS_WRITE,
    input  logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic        AVS_WAITREQUEST,
    output logic        TXD,
    input  logic        RXD,
    output logic        IRQ
);
    sib_pkg::sib_state_t s_reg;
    sib_pkg::sib_state_t s_next;
    sib_pkg::sib_samp_t  smp;
    sib_pkg::sib_load_t  ld_kind;
    logic                tick;
    logic                req;
    logic                rd_acc;
    logic                wr_acc;
    logic                tx_en;
    logic                send_break_bit;
    logic                break_detect_enable;
    logic                lng;
    logic                bit_end;
    logic                bit_last;
    logic                tx_free;
    logic                ld;
    logic                samp;
    logic                zc_hit;
    logic                bkd_evt;
    logic                post;
    logic                post_brk;
    logic                post_fe;
    logic [3:0]          brk_len;
    logic [3:0]          nbits;
    logic [3:0]          zc_new;
    logic [8:0]          view;
    logic [8:0]          rx_word;

    sib_baud u_baud (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .div  (s_reg.baud),
        .tick (tick)
    );

    sib_rx_sample u_samp (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .tick (tick),
        .rxd  (RXD),
        .smp  (smp)
    );

    // one wait state per access keeps read data registered
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~s_reg.pend;
    assign rd_acc = AVS_READ & s_reg.pend;
    assign wr_acc = AVS_WRITE & s_reg.pend;
    assign AVS_READDATA = s_reg.rdata;
    assign IRQ = s_reg.irq;
    assign TXD = s_reg.tx_busy ? s_reg.tx_sh[0] : 1'b1;

    assign view = {s_reg.rx_st != sib_pkg::RX_IDLE, s_reg.flags[7:2],
                   ~s_reg.tx_busy & s_reg.tx_buffer_empty_flag, s_reg.tx_buffer_empty_flag};
    assign lng = s_reg.c1[sib_pkg::C1_LONG];
    assign brk_len = lng ? sib_pkg::BRK_LONG : sib_pkg::BRK_SHORT;
    assign nbits = lng ? sib_pkg::BITS_LONG : sib_pkg::BITS_SHORT;
    assign rx_word = lng ? s_reg.rx_sh : {1'b0, s_reg.rx_sh[8:1]};

    always_comb begin
        s_next = s_reg;
        ld = 1'b0;
        ld_kind = sib_pkg::LD_DATA;
        post = 1'b0;
        post_brk = 1'b0;
        post_fe = 1'b0;
        bkd_evt = 1'b0;

        // register bus
        s_next.pend = req & ~s_reg.pend;
        if (req && !s_reg.pend) begin
            case (AVS_ADDRESS)
                sib_pkg::OFS_BAUD:  s_next.rdata = {19'h0, s_reg.baud};
                sib_pkg::OFS_CTRL1: s_next.rdata = {29'h0, s_reg.c1};
                sib_pkg::OFS_CTRL2: s_next.rdata = {28'h0, s_reg.c2};
                sib_pkg::OFS_FLAGS: s_next.rdata = {23'h0, view};
                sib_pkg::OFS_MASK:  s_next.rdata = {23'h0, s_reg.mask};
                sib_pkg::OFS_DATA:  s_next.rdata = {23'h0, s_reg.rx_data};
                default:            s_next.rdata = 32'h0;
            endcase
        end
        if (wr_acc) begin
            case (AVS_ADDRESS)
                sib_pkg::OFS_BAUD:  s_next.baud = AVS_WRITEDATA[12:0];
                sib_pkg::OFS_CTRL1: s_next.c1 = AVS_WRITEDATA[2:0];
                sib_pkg::OFS_CTRL2: s_next.c2 = AVS_WRITEDATA[3:0];
                sib_pkg::OFS_FLAGS: s_next.flags = s_reg.flags &
                    ~(AVS_WRITEDATA[8:0] & sib_pkg::STICKY);
                sib_pkg::OFS_MASK:  s_next.mask = AVS_WRITEDATA[8:0];
                sib_pkg::OFS_DATA: begin
                    s_next.tx_buf = AVS_WRITEDATA[8:0];
                    s_next.tx_buffer_empty_flag = 1'b0;
                end
                default: ;
            endcase
        end
        if (rd_acc && AVS_ADDRESS == sib_pkg::OFS_DATA)
            s_next.flags[sib_pkg::F_RX_FULL_FLAG] = 1'b0;

        // transmitter
        tx_en = s_next.c2[sib_pkg::C2_TX_EN];
        send_break_bit = s_next.c2[sib_pkg::C2_SBK];
        break_detect_enable = s_next.c2[sib_pkg::C2_BKD_EN];
        if (tx_en && !s_reg.c2[sib_pkg::C2_TX_EN])
            s_next.pre_pend = 1'b1;
        bit_end = s_reg.tx_busy & tick & (s_reg.tx_sub == sib_pkg::SUB_LAST);
        bit_last = bit_end & (s_reg.tx_cnt == sib_pkg::MARK_BITS);
        if (s_reg.tx_busy && tick) s_next.tx_sub = s_reg.tx_sub + 4'h1;
        // the frame in flight runs on whatever enable does
        if (bit_end) begin
            s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
            s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
        end
        if (bit_last) s_next.tx_busy = 1'b0;
        tx_free = ~s_reg.tx_busy | bit_last;
        // nothing new is loaded while disabled, so the line idles
        if (tx_free && tx_en) begin
            ld = 1'b1;
            if (send_break_bit) ld_kind = sib_pkg::LD_BREAK;
            else if (s_reg.brk_tail) ld_kind = sib_pkg::LD_MARK;
            else if (s_next.pre_pend) ld_kind = sib_pkg::LD_PREAMBLE;
            else if (!s_next.tx_buffer_empty_flag) ld_kind = sib_pkg::LD_DATA;
            else ld = 1'b0;
        end
        if (ld) begin
            s_next.tx_busy = 1'b1;
            s_next.tx_sub = 4'h0;
            s_next.tx_kind = ld_kind;
            s_next.brk_tail = (ld_kind == sib_pkg::LD_BREAK);
            s_next.tx_cnt = brk_len;
            case (ld_kind)
                sib_pkg::LD_BREAK: s_next.tx_sh = 11'h000;
                sib_pkg::LD_MARK: begin
                    s_next.tx_sh = sib_pkg::LINE_ONES;
                    s_next.tx_cnt = sib_pkg::MARK_BITS;
                end
                sib_pkg::LD_PREAMBLE: begin
                    s_next.tx_sh = sib_pkg::LINE_ONES;
                    s_next.pre_pend = 1'b0;
                end
                default: begin
                    s_next.tx_sh = sib_pkg::sib_frame(s_next.tx_buf, lng,
                        s_reg.c1[sib_pkg::C1_PAR_EN],
                        s_reg.c1[sib_pkg::C1_PAR_ODD]);
                    s_next.tx_buffer_empty_flag = 1'b1;
                end
            endcase
        end

        // receiver: zero run counted across frame ends
        samp = tick & (s_reg.rx_sub == sib_pkg::SUB_MID);
        if (tick && s_reg.rx_st != sib_pkg::RX_IDLE)
            s_next.rx_sub = s_reg.rx_sub + 4'h1;
        zc_new = smp.maj ? 4'h0 : ((s_reg.rx_zc == brk_len) ?
                 s_reg.rx_zc : s_reg.rx_zc + 4'h1);
        zc_hit = samp & ~smp.maj & (s_reg.rx_zc == brk_len - 4'h1) &
                 (s_reg.rx_st == sib_pkg::RX_BITS ||
                  s_reg.rx_st == sib_pkg::RX_WAIT_HI);
        if (samp && smp.noisy && s_reg.rx_st != sib_pkg::RX_IDLE)
            s_next.flags[sib_pkg::F_NOISE] = 1'b1;
        case (s_reg.rx_st)
            sib_pkg::RX_IDLE: begin
                if (tick && s_reg.c2[sib_pkg::C2_RX_EN] && !RXD) begin
                    s_next.rx_st = sib_pkg::RX_START;
                    s_next.rx_sub = 4'h0;
                    s_next.rx_zc = 4'h0;
                end
            end
            sib_pkg::RX_START: begin
                if (samp && smp.maj) begin
                    s_next.rx_st = sib_pkg::RX_IDLE;
                end else if (samp) begin
                    s_next.rx_st = sib_pkg::RX_BITS;
                    s_next.rx_cnt = 4'h0;
                    s_next.rx_zc = zc_new;
                end
            end
            sib_pkg::RX_BITS: begin
                if (samp) begin
                    s_next.rx_zc = zc_new;
                    if (s_reg.rx_cnt != nbits) begin
                        s_next.rx_sh = {smp.maj, s_reg.rx_sh[8:1]};
                        s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    end else begin
                        s_next.rx_st = smp.maj ? sib_pkg::RX_IDLE :
                                       sib_pkg::RX_WAIT_HI;
                        if (zc_hit && !break_detect_enable) begin
                            post = 1'b1;
                            post_brk = 1'b1;
                        end else if (!break_detect_enable || smp.maj) begin
                            post = 1'b1;
                            post_fe = ~smp.maj;
                        end else begin
                            // hold a bad stop until we know it is no break
                            s_next.rx_hold = 1'b1;
                        end
                    end
                end
            end
            sib_pkg::RX_WAIT_HI: begin
                if (samp) begin
                    s_next.rx_zc = zc_new;
                    if (smp.maj) begin
                        s_next.rx_st = sib_pkg::RX_IDLE;
                        post = s_reg.rx_hold;
                        post_fe = 1'b1;
                        s_next.rx_hold = 1'b0;
                    end
                end
            end
            default: s_next.rx_st = sib_pkg::RX_IDLE;
        endcase
        if (zc_hit && break_detect_enable) begin
            bkd_evt = 1'b1;
            post = 1'b0;
            s_next.rx_hold = 1'b0;
            s_next.rx_st = sib_pkg::RX_WAIT_HI;
            s_next.flags[sib_pkg::F_BRK] = 1'b1;
        end
        // hardware sets land after software clears, so sets win
        if (post) begin
            if (s_next.flags[sib_pkg::F_RX_FULL_FLAG])
                s_next.flags[sib_pkg::F_OVR] = 1'b1;
            if (post_brk) begin
                s_next.rx_data = 9'h000;
                s_next.flags[sib_pkg::F_RX_FULL_FLAG] = 1'b1;
                s_next.flags[sib_pkg::F_FRAME] = 1'b1;
            end else if (!s_next.flags[sib_pkg::F_RX_FULL_FLAG]) begin
                s_next.rx_data = rx_word;
                s_next.flags[sib_pkg::F_RX_FULL_FLAG] = 1'b1;
                if (post_fe) s_next.flags[sib_pkg::F_FRAME] = 1'b1;
                if (s_reg.c1[sib_pkg::C1_PAR_EN] &&
                    ((lng ? rx_word[8] : rx_word[7]) !=
                     sib_pkg::sib_par(rx_word, lng,
                                      s_reg.c1[sib_pkg::C1_PAR_ODD])))
                    s_next.flags[sib_pkg::F_PAR] = 1'b1;
            end
        end
        s_next.irq = |(view & s_reg.mask);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s_reg <= '0;
            s_reg.baud <= sib_pkg::BAUD_RST;
            s_reg.tx_buffer_empty_flag <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence brk_start;
        ld && ld_kind == sib_pkg::LD_BREAK;
    endsequence

    sequence brk_done;
        bit_last && s_reg.tx_kind == sib_pkg::LD_BREAK && !send_break_bit && tx_en;
    endsequence

    idle_after_frame_a: assert property (
        (bit_last && !ld) |=> !s_reg.tx_busy && TXD)
        else $error("line not idle after frame end");

    tx_off_quiet_a: assert property (
        (!s_reg.c2[sib_pkg::C2_TX_EN] && !s_reg.tx_busy && !wr_acc)
        |=> !s_reg.tx_busy && TXD)
        else $error("transmitter started while disabled");

    frame_finish_a: assert property (
        (s_reg.tx_busy && !tx_en && !bit_last) |=> s_reg.tx_busy)
        else $error("frame cut short by disable");

    tx_buffer_empty_flag_on_load_a: assert property (
        (ld && ld_kind == sib_pkg::LD_DATA)
        |=> s_reg.tx_buffer_empty_flag && s_reg.tx_busy && !TXD)
        else $error("buffer empty not raised on load");

    preamble_first_a: assert property (
        (s_reg.pre_pend && tx_free && tx_en && !send_break_bit && !s_reg.brk_tail)
        |=> s_reg.tx_kind == sib_pkg::LD_PREAMBLE && s_reg.tx_busy)
        else $error("queued preamble not sent first");

    break_load_a: assert property (
        brk_start |=> s_reg.tx_busy && s_reg.tx_sh == 11'h000 && !TXD)
        else $error("break not loaded");

    break_length_a: assert property (
        brk_start |=> s_reg.tx_cnt == (s_reg.c1[sib_pkg::C1_LONG] ?
                      sib_pkg::BRK_LONG : sib_pkg::BRK_SHORT))
        else $error("break length wrong");

    break_repeat_a: assert property (
        (bit_last && s_reg.tx_kind == sib_pkg::LD_BREAK && send_break_bit && tx_en)
        |=> s_reg.tx_busy && s_reg.tx_kind == sib_pkg::LD_BREAK)
        else $error("break not repeated");

    break_tail_a: assert property (
        brk_done |=> s_reg.tx_kind == sib_pkg::LD_MARK && TXD &&
                     s_reg.tx_cnt == sib_pkg::MARK_BITS)
        else $error("no mark bit after break");

    rx_break_len_a: assert property (
        post_brk |=> s_reg.rx_zc == (s_reg.c1[sib_pkg::C1_LONG] ?
                     sib_pkg::BRK_LONG : sib_pkg::BRK_SHORT))
        else $error("break seen at wrong zero count");

    break_plain_a: assert property (
        post_brk |=> s_reg.flags[sib_pkg::F_FRAME] &&
                     s_reg.flags[sib_pkg::F_RX_FULL_FLAG] && s_reg.rx_data == 9'h000)
        else $error("plain break flags wrong");

    break_flag_a: assert property (
        bkd_evt |=> s_reg.flags[sib_pkg::F_BRK] &&
                    s_reg.rx_st == sib_pkg::RX_WAIT_HI)
        else $error("break detect flag not set");

    break_quiet_a: assert property (
        (bkd_evt && !wr_acc && !rd_acc) |=> $stable(s_reg.rx_data) &&
        $stable({s_reg.flags[6:5], s_reg.flags[3:2]}))
        else $error("break disturbed receive state");
endmodule : sib_top

// ==== tb/sib_remote.sv ====
// remote serial device model driving the receive line
`timescale 1ns/100ps
module sib_remote (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] bits,
    input  wire logic [4:0]  len,
    output logic             rxd,
    output logic             busy
);
    logic [15:0] sh_reg = 16'h0;
    logic [4:0]  cnt_reg = 5'h0;
    logic [3:0]  sub_reg = 4'h0;
    // the line rests at mark between frames, so a stale zero never lingers
    assign rxd = busy ? sh_reg[0] : 1'b1;
    assign busy = cnt_reg != 5'h0;
    // sixteen clocks per bit, matching a divider of one
    always_ff @(posedge clk) begin
        if (go) begin
            sh_reg <= bits;
            cnt_reg <= len;
            sub_reg <= 4'h0;
        end else if (busy) begin
            sub_reg <= sub_reg + 4'h1;
            if (sub_reg == 4'hf) begin
                sh_reg <= sh_reg >> 1;
                cnt_reg <= cnt_reg - 5'h1;
            end
        end
    end
endmodule : sib_remote

// ==== tb/sib_top_tb.sv ====
// self-checking bench for the serial idle and break block
`timescale 1ns/100ps
module sib_top_tb;
    logic        SYS_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [5:0]  adr = 6'h0;
    logic        rd_q = 1'b0;
    logic        wr_q = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        TXD;
    logic        RXD;
    logic        IRQ;
    logic        go = 1'b0;
    logic [15:0] pat = 16'h0;
    logic [4:0]  plen = 5'h0;
    logic        pbusy;
    logic [31:0] seed = 32'h7d4ad2fc;
    logic [10:0] fr;
    int          num_errors = 0;
    int          checks = 0;
    int          n;
    time         t0;
    time         tf;
    always #50 SYS_CLK = ~SYS_CLK;
    sib_top u_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
        .AVS_ADDRESS(adr), .AVS_READ(rd_q), .AVS_WRITE(wr_q),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .TXD(TXD), .RXD(RXD), .IRQ(IRQ));
    sib_remote u_rem (.clk(SYS_CLK), .go(go), .bits(pat), .len(plen),
        .rxd(RXD), .busy(pbusy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [10:0] frm(input logic [8:0] d, input logic m);
        return m ? {1'b1, d, 1'b0} : {2'b01, d[7:0], 1'b0};
    endfunction : frm
    task automatic wrap_up(input int bad);
        num_errors += bad;
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge SYS_CLK);
        adr <= a;
        wdat <= d;
        wr_q <= w;
        rd_q <= !w;
        // waitrequest and read data are taken at the same rising edge
        @(posedge SYS_CLK);
        for (i = 0; i < 20 && wreq !== 1'b0; i++) @(posedge SYS_CLK);
        if (i == 20) wrap_up(1);
        q = rdat;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(q & m, e);
    endtask : rd
    task automatic fall(output time t);
        int i;
        for (i = 0; i < 3000 && TXD !== 1'b0; i++) @(negedge SYS_CLK);
        if (i == 3000) wrap_up(1);
        t = $time;
    endtask : fall
    // samples each bit mid-cell; off drops transmit enable inside the start bit
    task automatic grab(input int nb, input logic off,
                        output logic [10:0] v, output time t);
        v = 11'h0;
        fall(t);
        if (off) wr(sib_pkg::OFS_CTRL2, 32'h2);
        while ($time < t + 800) @(negedge SYS_CLK);
        for (int k = 0; k < nb; k++) begin
            v[k] = TXD;
            repeat (16) @(negedge SYS_CLK);
        end
    endtask : grab
    task automatic send(input logic [15:0] b, input logic [4:0] l);
        int i;
        @(posedge SYS_CLK);
        pat <= b;
        plen <= l;
        go <= 1'b1;
        @(posedge SYS_CLK);
        go <= 1'b0;
        // busy only shows once the model has taken go
        @(negedge SYS_CLK);
        for (i = 0; i < 400 && pbusy !== 1'b0; i++) @(negedge SYS_CLK);
        if (i == 400) wrap_up(1);
        repeat (40) @(negedge SYS_CLK);
    endtask : send
    initial begin
        repeat (10) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        rd(sib_pkg::OFS_FLAGS, 32'h3, 32'h1ff);
        rd(sib_pkg::OFS_BAUD, 32'h41, 32'hffffffff);
        rd(6'h3c, 32'h0, 32'hffffffff);
        wr(sib_pkg::OFS_BAUD, 32'h1);
        cmp(TXD, 1'b1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(sib_pkg::OFS_CTRL1, {31'h0, seed[9]});
            wr(sib_pkg::OFS_CTRL2, 32'h2);
            wr(sib_pkg::OFS_CTRL2, 32'h3);
            wr(sib_pkg::OFS_DATA, seed);
            t0 = $time;
            rd(sib_pkg::OFS_FLAGS, 32'h0, 32'h3);
            grab(seed[9] ? 11 : 10, i[0], fr, tf);
            cmp(32'((tf - t0) / 100) >= 140, 1'b1);
            cmp(fr, frm(seed[8:0], seed[9]));
            if (i[0]) begin
                wr(sib_pkg::OFS_DATA, 32'h55);
                n = 0;
                repeat (300) @(negedge SYS_CLK) n += (TXD !== 1'b1);
                cmp(n, 0);
            end
        end
        for (int m = 0; m < 2; m++) begin
            wr(sib_pkg::OFS_CTRL1, m);
            fork
                wr(sib_pkg::OFS_CTRL2, 32'h7);
                fall(t0);
            join
            repeat (200) @(negedge SYS_CLK);
            seed = lfsr(seed);
            wr(sib_pkg::OFS_DATA, seed);
            wr(sib_pkg::OFS_CTRL2, 32'h3);
            for (n = 0; n < 400 && TXD === 1'b0; n++) @(negedge SYS_CLK);
            cmp(32'(($time - t0) / 100), 32 * (10 + m));
            t0 = $time;
            grab(10 + m, 1'b0, fr, tf);
            cmp(32'((tf - t0) / 100) >= 16, 1'b1);
            cmp(fr, frm(seed[8:0], m[0]));
        end
        wr(sib_pkg::OFS_CTRL1, 32'h0);
        wr(sib_pkg::OFS_CTRL2, 32'h2);
        wr(sib_pkg::OFS_FLAGS, 32'hfc);
        wr(sib_pkg::OFS_MASK, 32'h20);
        send(16'hfe00, 5'h9);
        rd(sib_pkg::OFS_FLAGS, 32'h04, 32'hac);
        rd(sib_pkg::OFS_DATA, 32'h0, 32'h1ff);
        seed = lfsr(seed);
        send({6'h3f, 1'b1, seed[7:0], 1'b0}, 5'ha);
        rd(sib_pkg::OFS_DATA, seed[7:0], 32'h1ff);
        cmp(IRQ, 1'b0);
        send(16'h0, 5'hc);
        rd(sib_pkg::OFS_FLAGS, 32'h24, 32'hac);
        cmp(IRQ, 1'b1);
        rd(sib_pkg::OFS_DATA, 32'h0, 32'h1ff);
        wr(sib_pkg::OFS_FLAGS, 32'hfc);
        repeat (3) @(negedge SYS_CLK);
        cmp(IRQ, 1'b0);
        wr(sib_pkg::OFS_CTRL2, 32'ha);
        seed = lfsr(seed);
        send({6'h3f, 1'b1, seed[7:0], 1'b0}, 5'ha);
        send(16'h0006, 5'h10);
        rd(sib_pkg::OFS_FLAGS, 32'h84, 32'hec);
        rd(sib_pkg::OFS_DATA, seed[7:0], 32'h1ff);
        wrap_up(0);
    end
endmodule : sib_top_tb
